// [rtl/cfc_pkg.sv]
// Constants, field layouts and carrier types for the carrier frequency control block
package cfc_pkg;

    // ------------------------------------------------------------------
    // Clock and units
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int CLK_FREQ_HZ   = 40_000_000;
    localparam int FREQ_UNIT_HZ  = 100;

    // ------------------------------------------------------------------
    // Carrier limits in 0.1 kHz units and the sensorless vector method code
    // ------------------------------------------------------------------
    localparam logic [7:0] FREQ_MIN       = 8'h14;
    localparam logic [7:0] ND_FREQ_MAX    = 8'h96;
    localparam logic [7:0] LD_FREQ_MAX    = 8'h64;
    localparam logic [7:0] REDUCE_FLOOR   = 8'h1E;
    localparam logic [7:0] SLV_LOW_CARR   = 8'h14;
    localparam logic [7:0] SLV_METHOD     = 8'h03;

    // ------------------------------------------------------------------
    // Slew timing
    // ------------------------------------------------------------------
    localparam int SLEW_RATE_HZ_PER_S = 2000;
    localparam int SLEW_STEP_MS       = FREQ_UNIT_HZ * 1000 / SLEW_RATE_HZ_PER_S;
    localparam int SLEW_STEP_CYCLES   = SLEW_STEP_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam logic [31:0] PHASE_STEP =
        32'((64'h1_0000_0000 * 64'(FREQ_UNIT_HZ)) / 64'(CLK_FREQ_HZ));

    // ------------------------------------------------------------------
    // Reduction thresholds with hysteresis, and the sensorless vector speed ramp
    // ------------------------------------------------------------------
    localparam logic [7:0]  CUR_ON_PCT     = 8'h5A;
    localparam logic [7:0]  CUR_OFF_PCT    = 8'h50;
    localparam logic [7:0]  TEMP_ON_DEGC   = 8'h50;
    localparam logic [7:0]  TEMP_OFF_DEGC  = 8'h46;
    localparam logic [15:0] SLV_LOW_SPEED  = 16'h0032;
    localparam int          SLV_RAMP_SHIFT = 3;

    // ------------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL     = 4'h0;
    localparam logic [3:0] ADDR_MAXF     = 4'h1;
    localparam logic [3:0] ADDR_STAT     = 4'h2;
    localparam int         CTRL_SET_LSB  = 0;
    localparam int         CTRL_SEL_LSB  = 8;
    localparam int         CTRL_DUTY_BIT = 10;
    localparam int         CTRL_METH_LSB = 16;
    localparam logic [7:0]  SET_RST      = 8'h50;
    localparam logic [15:0] MAXF_RST     = 16'h0258;
    localparam logic [1:0]  RED_SEL_OFF  = 2'h0;
    localparam logic [1:0]  RED_SEL_CUR  = 2'h1;
    localparam logic [1:0]  RED_SEL_TEMP = 2'h2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {MODE_BYPASS, MODE_RESTORE, MODE_REDUCE} cfc_mode_type;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } cfc_bus_type;

    typedef struct packed {
        logic [7:0]  out_cur_pct;
        logic [7:0]  fin_temp;
        logic [15:0] out_freq;
        logic        dc_brake;
    } cfc_meas_type;

endpackage

// [rtl/cfc_top.sv]
// Carrier frequency selection, automatic reduction, slewing and carrier timing
// Function
// - In normal duty the carrier setting is held between 2.0 kHz and 15.0 kHz.
// - In light duty the carrier setting is held between 2.0 kHz and 10.0 kHz.
// - The allowed setting range follows the duty type and out-of-range values are clamped.
// - Under sensorless vector control (code 03) the carrier runs at 2 kHz at low speed.
// - Under sensorless vector control the carrier rises with output frequency.
// - Reduction select 00 is off, 01 follows output current, 02 follows fin temperature.
// - While reduction is active the carrier stays between the setting and 3 kHz unless the sensorless vector cap is lower.
// - A setting below 3 kHz disables automatic reduction.
// - Reduction moves the carrier at 2 kHz per second, never in a step.
// - Current-driven reduction lowers the carrier when current passes a fixed fraction.
// - Current-driven reduction returns to the setting when current falls again.
// - Temperature-driven reduction lowers and restores the carrier around a fin threshold.
// - DC braking may lower the carrier as well.
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module cfc_top #(
    parameter int SLEW_CYCLES = cfc_pkg::SLEW_STEP_CYCLES
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  sys_rst_i,
    input  wire cfc_pkg::cfc_bus_type  reg_bus_i,
    input  wire cfc_pkg::cfc_meas_type meas_i,
    output logic [31:0]                reg_rdata_o,
    output logic                       carrier_tick_o,
    output logic [7:0]                 carrier_freq_o,
    output logic [7:0]                 carrier_phase_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]            setting;
        logic [1:0]            red_sel;
        logic                  duty_ld;
        logic [7:0]            method;
        logic [15:0]           max_freq;
        logic                  cur_hi;
        logic                  temp_hi;
        cfc_pkg::cfc_mode_type mode;
        logic [7:0]            slew_freq;
        logic [23:0]           slew_cnt;
        logic [7:0]            actual;
        logic [31:0]           phase;
        logic                  tick;
        logic [31:0]           rdata;
    } cfc_state_type;

    cfc_state_type st;
    cfc_state_type next_st;

    // ------------------------------------------------------------------
    // Combinational helpers
    // ------------------------------------------------------------------
    logic [7:0]  duty_max;
    logic [7:0]  wr_set;
    logic [7:0]  wr_max;
    logic        cur_on;
    logic        cur_off;
    logic        temp_on;
    logic        temp_off;
    logic        red_req;
    logic        red_allowed;
    logic        red_active;
    logic [7:0]  goal;
    logic        slew_step;
    logic        slew_dn;
    logic        slew_up;
    logic [15:0] slv_span;
    logic [7:0]  slv_cap;
    logic        slv_on;
    logic [7:0]  applied;
    logic [31:0] carrier_inc;
    logic [32:0] phase_sum;
    logic        advice_low;

    logic [31:0] ctrl_word;
    logic [31:0] maxf_word;
    logic [31:0] stat_word;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_st       = st;
        next_st.tick  = 1'b0;
        next_st.rdata = 32'h0000_0000;

        // --------------------------------------------------------------
        // Range follows duty type
        // --------------------------------------------------------------
        // Ceiling of the setting for the current duty type
        if (st.duty_ld) begin
            duty_max = cfc_pkg::LD_FREQ_MAX;
        end else begin
            duty_max = cfc_pkg::ND_FREQ_MAX;
        end
        // Duty switched after the setting was written
        if (st.setting > duty_max) begin
            next_st.setting = duty_max;
        end

        // --------------------------------------------------------------
        // Register writes
        // --------------------------------------------------------------
        // Out-of-range writes are clamped, never refused
        wr_set = reg_bus_i.wdata[cfc_pkg::CTRL_SET_LSB +: 8];
        if (reg_bus_i.wdata[cfc_pkg::CTRL_DUTY_BIT]) begin
            wr_max = cfc_pkg::LD_FREQ_MAX;
        end else begin
            wr_max = cfc_pkg::ND_FREQ_MAX;
        end
        if (reg_bus_i.wr) begin
            case (reg_bus_i.addr)
                cfc_pkg::ADDR_CTRL: begin
                    if (wr_set < cfc_pkg::FREQ_MIN) begin
                        next_st.setting = cfc_pkg::FREQ_MIN;
                    end else if (wr_set > wr_max) begin
                        next_st.setting = wr_max;
                    end else begin
                        next_st.setting = wr_set;
                    end
                    next_st.red_sel = reg_bus_i.wdata[cfc_pkg::CTRL_SEL_LSB +: 2];
                    next_st.duty_ld = reg_bus_i.wdata[cfc_pkg::CTRL_DUTY_BIT];
                    next_st.method  = reg_bus_i.wdata[cfc_pkg::CTRL_METH_LSB +: 8];
                end
                cfc_pkg::ADDR_MAXF: begin
                    next_st.max_freq = reg_bus_i.wdata[15:0];
                end
                default: begin
                end
            endcase
        end

        // --------------------------------------------------------------
        // Hysteresis detectors
        // --------------------------------------------------------------
        // Gap between on and off levels stops the carrier from hunting
        cur_on   = (meas_i.out_cur_pct > cfc_pkg::CUR_ON_PCT);
        cur_off  = (meas_i.out_cur_pct < cfc_pkg::CUR_OFF_PCT);
        temp_on  = (meas_i.fin_temp > cfc_pkg::TEMP_ON_DEGC);
        temp_off = (meas_i.fin_temp < cfc_pkg::TEMP_OFF_DEGC);
        if (cur_on) begin
            next_st.cur_hi = 1'b1;
        end else if (cur_off) begin
            next_st.cur_hi = 1'b0;
        end
        if (temp_on) begin
            next_st.temp_hi = 1'b1;
        end else if (temp_off) begin
            next_st.temp_hi = 1'b0;
        end

        // --------------------------------------------------------------
        // Reduction source
        // --------------------------------------------------------------
        case (st.red_sel)
            cfc_pkg::RED_SEL_CUR: begin
                red_req = st.cur_hi;
            end
            cfc_pkg::RED_SEL_TEMP: begin
                red_req = st.temp_hi;
            end
            default: begin
                red_req = 1'b0;
            end
        endcase
        red_allowed = (st.setting >= cfc_pkg::REDUCE_FLOOR);
        // Braking asks for the same floor as automatic reduction
        red_active  = red_req || meas_i.dc_brake;

        // Low settings bypass reduction entirely
        if (!red_allowed) begin
            next_st.mode = cfc_pkg::MODE_BYPASS;
        end else if (red_active) begin
            next_st.mode = cfc_pkg::MODE_REDUCE;
        end else begin
            next_st.mode = cfc_pkg::MODE_RESTORE;
        end

        // --------------------------------------------------------------
        // Slew toward goal
        // --------------------------------------------------------------
        // One unit per SLEW_CYCLES keeps the rate fixed
        slew_step = (st.slew_cnt >= 24'(SLEW_CYCLES - 1));
        if (slew_step) begin
            next_st.slew_cnt = 24'h00_0000;
        end else begin
            next_st.slew_cnt = st.slew_cnt + 24'h00_0001;
        end

        // Target is the floor while reducing, else the setting
        case (st.mode)
            cfc_pkg::MODE_REDUCE: begin
                goal = cfc_pkg::REDUCE_FLOOR;
            end
            cfc_pkg::MODE_RESTORE: begin
                goal = st.setting;
            end
            default: begin
                goal = st.setting;
            end
        endcase

        slew_dn = slew_step && (st.slew_freq > goal);
        slew_up = slew_step && (st.slew_freq < goal);
        // Software lowering the setting takes effect at once
        if (st.mode == cfc_pkg::MODE_BYPASS) begin
            next_st.slew_freq = st.setting;
        end else if (st.slew_freq > st.setting) begin
            next_st.slew_freq = st.setting;
        end else if (st.slew_freq < cfc_pkg::REDUCE_FLOOR) begin
            next_st.slew_freq = cfc_pkg::REDUCE_FLOOR;
        end else if (slew_dn) begin
            next_st.slew_freq = st.slew_freq - 8'h01;
        end else if (slew_up) begin
            next_st.slew_freq = st.slew_freq + 8'h01;
        end

        // --------------------------------------------------------------
        // Sensorless vector speed cap
        // --------------------------------------------------------------
        // Cap rises with output frequency above the low-speed point
        slv_on = (st.method == cfc_pkg::SLV_METHOD);
        if (meas_i.out_freq < cfc_pkg::SLV_LOW_SPEED) begin
            slv_span = 16'h0000;
        end else begin
            slv_span = (meas_i.out_freq - cfc_pkg::SLV_LOW_SPEED)
                       >> cfc_pkg::SLV_RAMP_SHIFT;
        end
        if (slv_span > 16'(8'hFF - cfc_pkg::SLV_LOW_CARR)) begin
            slv_cap = 8'hFF;
        end else begin
            slv_cap = cfc_pkg::SLV_LOW_CARR + slv_span[7:0];
        end
        if (slv_on && slv_cap < st.slew_freq) begin
            applied = slv_cap;
        end else begin
            applied = st.slew_freq;
        end

        // --------------------------------------------------------------
        // Carrier phase accumulator
        // --------------------------------------------------------------
        // Period ends on accumulator carry, so no carrier cycle is cut short
        carrier_inc   = 32'(st.actual) * cfc_pkg::PHASE_STEP;
        phase_sum     = {1'b0, st.phase} + {1'b0, carrier_inc};
        next_st.phase = phase_sum[31:0];
        if (phase_sum[32]) begin
            next_st.tick   = 1'b1;
            next_st.actual = applied;
        end

        // --------------------------------------------------------------
        // Setting below ten times maximum output frequency
        // --------------------------------------------------------------
        advice_low = (24'(st.setting) * 24'(cfc_pkg::FREQ_UNIT_HZ))
                     < 24'(st.max_freq);

        // --------------------------------------------------------------
        // Read words
        // --------------------------------------------------------------
        // Assembled every cycle, latched only on a read
        ctrl_word = 32'h0000_0000;
        ctrl_word[cfc_pkg::CTRL_SET_LSB +: 8]  = st.setting;
        ctrl_word[cfc_pkg::CTRL_SEL_LSB +: 2]  = st.red_sel;
        ctrl_word[cfc_pkg::CTRL_DUTY_BIT]      = st.duty_ld;
        ctrl_word[cfc_pkg::CTRL_METH_LSB +: 8] = st.method;

        maxf_word       = 32'h0000_0000;
        maxf_word[15:0] = st.max_freq;

        stat_word        = 32'h0000_0000;
        stat_word[7:0]   = st.actual;
        stat_word[15:8]  = st.slew_freq;
        stat_word[16]    = (st.mode == cfc_pkg::MODE_REDUCE);
        stat_word[17]    = advice_low;
        stat_word[18]    = st.cur_hi;
        stat_word[19]    = st.temp_hi;

        // --------------------------------------------------------------
        // Register reads
        // --------------------------------------------------------------
        if (reg_bus_i.rd) begin
            case (reg_bus_i.addr)
                cfc_pkg::ADDR_CTRL: begin
                    next_st.rdata = ctrl_word;
                end
                cfc_pkg::ADDR_MAXF: begin
                    next_st.rdata = maxf_word;
                end
                cfc_pkg::ADDR_STAT: begin
                    next_st.rdata = stat_word;
                end
                default: begin
                    next_st.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            // Carrier starts at the reset setting with the phase at zero
            st.setting   <= cfc_pkg::SET_RST;
            st.red_sel   <= cfc_pkg::RED_SEL_OFF;
            st.duty_ld   <= 1'b0;
            st.method    <= 8'h00;
            st.max_freq  <= cfc_pkg::MAXF_RST;
            st.cur_hi    <= 1'b0;
            st.temp_hi   <= 1'b0;
            st.mode      <= cfc_pkg::MODE_RESTORE;
            st.slew_freq <= cfc_pkg::SET_RST;
            st.slew_cnt  <= 24'h00_0000;
            st.actual    <= cfc_pkg::SET_RST;
            st.phase     <= 32'h0000_0000;
            st.tick      <= 1'b0;
            st.rdata     <= 32'h0000_0000;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata_o     = st.rdata;
    assign carrier_tick_o  = st.tick;
    assign carrier_freq_o  = st.actual;
    assign carrier_phase_o = st.phase[31:24];

endmodule

`default_nettype wire

// [dv/cfc_assertions.sv]
// Port checks for the carrier frequency control block
`timescale 1ns/1ps
`default_nettype none

module cfc_assertions (
    input wire logic                  sys_clk_i,
    input wire logic                  sys_rst_i,
    input wire cfc_pkg::cfc_bus_type  reg_bus_i,
    input wire cfc_pkg::cfc_meas_type meas_i,
    input wire logic [31:0]           reg_rdata_o,
    input wire logic                  carrier_tick_o,
    input wire logic [7:0]            carrier_freq_o,
    input wire logic [7:0]            carrier_phase_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_freq_at_tick: assert property (
        !carrier_tick_o |-> $stable(carrier_freq_o)) else $error("carrier moved off boundary");
    a_tick_single: assert property (
        carrier_tick_o |=> !carrier_tick_o) else $error("tick longer than one cycle");
    a_tick_spacing: assert property (
        carrier_tick_o |=> !carrier_tick_o [*8]) else $error("carrier period too short");
    a_freq_range: assert property (
        carrier_freq_o >= 8'h14 && carrier_freq_o <= 8'h96) else $error("carrier out of range");
    a_rdata_idle: assert property (
        !$past(reg_bus_i.rd) |-> reg_rdata_o == 32'h0) else $error("read data without read");
    a_unmapped_zero: assert property (
        reg_bus_i.rd && reg_bus_i.addr > cfc_pkg::ADDR_STAT |=> reg_rdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_setting_clamp: assert property (
        reg_bus_i.rd && reg_bus_i.addr == cfc_pkg::ADDR_CTRL |=> reg_rdata_o[7:0] >= 8'h14
        && reg_rdata_o[7:0] <= (reg_rdata_o[10] ? 8'h64 : 8'h96)) else $error("setting unclamped");
    a_phase_wrap: assert property (
        carrier_tick_o |-> carrier_phase_o == 8'h00) else $error("tick away from phase wrap");
    a_stat_actual: assert property (
        reg_bus_i.rd && reg_bus_i.addr == cfc_pkg::ADDR_STAT |=>
        reg_rdata_o[7:0] == $past(carrier_freq_o)) else $error("status carrier differs");

    c_tick: cover property (carrier_tick_o);
    c_stat_read: cover property (reg_bus_i.rd && reg_bus_i.addr == cfc_pkg::ADDR_STAT);
    c_ctrl_write: cover property (reg_bus_i.wr && reg_bus_i.addr == cfc_pkg::ADDR_CTRL);
endmodule

bind cfc_top cfc_assertions cfc_assertions_inst (
    .sys_clk_i, .sys_rst_i, .reg_bus_i, .meas_i,
    .reg_rdata_o, .carrier_tick_o, .carrier_freq_o, .carrier_phase_o
);

`default_nettype wire

// [dv/cfc_stage_model.sv]
// Power stage model: measurement feedback and carrier adoption
`timescale 1ns/1ps
`default_nettype none

module cfc_stage_model (
    input  wire logic                  sys_clk_i,
    input  wire logic [7:0]            cur_i,
    input  wire logic [7:0]            temp_i,
    input  wire logic [15:0]           freq_i,
    input  wire logic                  brake_i,
    input  wire logic                  carrier_tick_i,
    input  wire logic [7:0]            carrier_freq_i,
    output wire cfc_pkg::cfc_meas_type meas_o,
    output logic [7:0]                 applied_o
);
    assign meas_o = '{out_cur_pct: cur_i, fin_temp: temp_i, out_freq: freq_i, dc_brake: brake_i};

    // Stage takes a new carrier only at a period boundary
    always_ff @(posedge sys_clk_i) begin
        if (carrier_tick_i) begin
            applied_o <= carrier_freq_i;
        end
    end
endmodule

`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the carrier frequency control block
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic                  sys_clk_i = 1'b0;
    logic                  sys_rst_i = 1'b1;
    cfc_pkg::cfc_bus_type  bus = '0;
    cfc_pkg::cfc_meas_type meas;
    logic [31:0]           rdata;
    logic [31:0]           got;
    logic                  tick;
    logic [7:0]            freq;
    logic [7:0]            applied;
    logic [7:0]            cur = 8'h00;
    logic [7:0]            temp = 8'h19;
    logic [15:0]           ofreq = 16'h0000;
    logic                  brake = 1'b0;
    logic [31:0]           wv [4] = '{32'h0FF, 32'h005, 32'h496, 32'h413};
    logic [7:0]            ev [4] = '{8'h96, 8'h14, 8'h64, 8'h14};
    int                    n_fail = 0;
    int                    check_count = 0;

    cfc_top #(.SLEW_CYCLES(4)) cfc_top_inst (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .reg_bus_i(bus), .meas_i(meas),
        .reg_rdata_o(rdata), .carrier_tick_o(tick), .carrier_freq_o(freq), .carrier_phase_o()
    );
    cfc_stage_model cfc_stage_model_inst (
        .sys_clk_i(sys_clk_i), .cur_i(cur), .temp_i(temp), .freq_i(ofreq), .brake_i(brake),
        .carrier_tick_i(tick), .carrier_freq_i(freq), .meas_o(meas), .applied_o(applied)
    );

    initial forever #12.5 sys_clk_i = ~sys_clk_i;

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_i);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk_i);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk_i);
        bus.rd <= 1'b0;
        #1 got = rdata;
        @(posedge sys_clk_i);
    endtask

    // Poll the slewed target with a bounded number of status reads
    task automatic poll(input logic [7:0] exp);
        for (int i = 0; i < 300 && got[15:8] !== exp; i++) rd(cfc_pkg::ADDR_STAT);
        check("target", 32'(got[15:8]), 32'(exp));
        if (got[15:8] !== exp) complete_run();
    endtask

    task automatic tick_chk(input logic [7:0] exp);
        int i;
        for (i = 0; i < 21000; i++) begin
            @(posedge sys_clk_i);
            #1;
            if (tick === 1'b1) break;
        end
        check("carrier", 32'(freq), 32'(exp));
        if (i == 21000) begin
            n_fail++;
            complete_run();
        end
        @(posedge sys_clk_i);
    endtask

    initial begin
        repeat (4) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        #1 check("carrier_rst", 32'(freq), 32'h50);
        rd(cfc_pkg::ADDR_CTRL);
        check("ctrl_rst", got, 32'h0000_0050);
        for (int k = 0; k < 4; k++) begin
            wr(cfc_pkg::ADDR_CTRL, wv[k]);
            rd(cfc_pkg::ADDR_CTRL);
            check("clamp", 32'(got[7:0]), 32'(ev[k]));
        end
        rd(4'hF);
        check("unmapped", got, 32'h0);
        wr(cfc_pkg::ADDR_MAXF, 32'h0000_0190);
        wr(cfc_pkg::ADDR_CTRL, 32'h0000_0128);
        tick_chk(8'h28);
        cur <= 8'h5B;
        rd(cfc_pkg::ADDR_STAT);
        rd(cfc_pkg::ADDR_STAT);
        check("slewing", 32'(got[15:8] > 8'h1E), 32'h1);
        check("cur_flag", 32'(got[18]), 32'h1);
        check("advice", 32'(got[17]), 32'h0);
        poll(8'h1E);
        tick_chk(8'h1E);
        cur <= 8'h55;
        repeat (40) @(posedge sys_clk_i);
        rd(cfc_pkg::ADDR_STAT);
        check("hysteresis", 32'(got[15:8]), 32'h1E);
        cur <= 8'h4F;
        poll(8'h28);
        tick_chk(8'h28);
        cur <= 8'h00;
        wr(cfc_pkg::ADDR_CTRL, 32'h0000_0228);
        temp <= 8'h51;
        poll(8'h1E);
        check("temp_flag", 32'(got[19]), 32'h1);
        temp <= 8'h45;
        poll(8'h28);
        wr(cfc_pkg::ADDR_CTRL, 32'h0000_0028);
        cur <= 8'h5B;
        repeat (60) @(posedge sys_clk_i);
        rd(cfc_pkg::ADDR_STAT);
        check("sel_off", 32'(got[15:8]), 32'h28);
        brake <= 1'b1;
        poll(8'h1E);
        brake <= 1'b0;
        poll(8'h28);
        wr(cfc_pkg::ADDR_CTRL, 32'h0000_011C);
        repeat (60) @(posedge sys_clk_i);
        rd(cfc_pkg::ADDR_STAT);
        check("below_floor", 32'(got[15:8]), 32'h1C);
        cur <= 8'h00;
        wr(cfc_pkg::ADDR_CTRL, 32'h0003_0050);
        tick_chk(8'h14);
        ofreq <= 16'h00D2;
        tick_chk(8'h28);
        @(posedge sys_clk_i);
        #1 check("applied", 32'(applied), 32'h28);
        complete_run();
    end
endmodule

`default_nettype wire
